// ==== rtl/ifeb_irq_flag_enable_bank.sv ====
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps


module ifeb_irq_flag_enable_bank
	import ifeb_pkg::*;
(
	input  wire logic        hclk,                 // system clock
	input  wire logic        hresetn,              // async reset, low
	input  wire logic        hsel,                 // slave select
	input  wire logic [31:0] haddr,                // byte address
	input  wire logic [1:0]  htrans,               // transfer type
	input  wire logic        hwrite,               // write when high
	input  wire logic [2:0]  hsize,                // word only
	input  wire logic [31:0] hwdata,               // write data
	input  wire logic        hready,               // bus ready
	output logic             hreadyout,            // always ready
	output logic             hresp,                // always okay
	output logic      [31:0] hrdata,               // read data
	input  wire logic        dma_ch5_done_req,     // source pulses
	input  wire logic        can2_event_req,
	input  wire logic        can2_rx_ready_req,
	input  wire logic        ext_irq4_req,
	input  wire logic        ext_irq3_req,
	input  wire logic        timer9_req,
	input  wire logic        timer8_req,
	input  wire logic        i2c2_master_event_req,
	input  wire logic        i2c2_slave_event_req,
	input  wire logic        timer7_req,
	input  wire logic        can2_tx_request_req,
	input  wire logic        can1_tx_request_req,
	input  wire logic        dma_ch7_done_req,
	input  wire logic        dma_ch6_done_req,
	input  wire logic        uart2_error_req,
	input  wire logic        uart1_error_req,
	input  wire logic [15:0] enables_3_in,         // enables for flags 3
	input  wire logic [15:0] enables_4_in,         // enables for flags 4
	input  wire logic [15:0] flags_0_in,           // flags for enables 0
	input  wire logic [15:0] flags_1_in,           // flags for enables 1
	input  wire logic [47:0] prio_3_in,            // codes, flags 3
	input  wire logic [47:0] prio_4_in,            // codes, flags 4
	input  wire logic [47:0] prio_0_in,            // codes, enables 0
	input  wire logic [47:0] prio_1_in,            // codes, enables 1
	output logic      [15:0] irq_flags_3,          // flag bank view
	output logic      [15:0] irq_flags_4,          // flag bank view
	output logic      [15:0] irq_enables_0,        // enable bank view
	output logic      [15:0] irq_enables_1,        // enable bank view
	output logic      [15:0] fwd_3,                // forwarded, flags 3
	output logic      [15:0] fwd_4,                // forwarded, flags 4
	output logic      [15:0] fwd_0,                // forwarded, enables 0
	output logic      [15:0] fwd_1,                // forwarded, enables 1
	output logic      [2:0]  level_3,              // top level, flags 3
	output logic      [2:0]  level_4,              // top level, flags 4
	output logic      [2:0]  level_0,              // top level, enables 0
	output logic      [2:0]  level_1               // top level, enables 1
);

	// word match on the decoded window; byte lanes are ignored
	function automatic logic word_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
	endfunction

	// write replaces the flags, but a set in the same cycle wins
	function automatic logic [15:0] next_flags(
		input logic [15:0] old,
		input logic        wr,
		input logic [15:0] wdata,
		input logic [15:0] set,
		input logic [15:0] impl
	);
		return ((wr ? wdata : old) | set) & impl;
	endfunction

	// enables only change on a write
	function automatic logic [15:0] next_enables(
		input logic [15:0] old,
		input logic        wr,
		input logic [15:0] wdata,
		input logic [15:0] impl
	);
		return (wr ? wdata : old) & impl;
	endfunction

	logic              addr_ok;
	logic              wr_pend_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [31:0]       hrdata_q;
	logic              wr_3;
	logic              wr_4;
	logic              wr_0;
	logic              wr_1;
	logic [15:0]       set_3;
	logic [15:0]       set_4;
	logic [15:0]       irq_flags_3_q;
	logic [15:0]       irq_flags_3_d;
	logic [15:0]       irq_flags_4_q;
	logic [15:0]       irq_flags_4_d;
	logic [15:0]       irq_enables_0_q;
	logic [15:0]       irq_enables_0_d;
	logic [15:0]       irq_enables_1_q;
	logic [15:0]       irq_enables_1_d;
	logic [15:0]       fwd_3_c;
	logic [15:0]       fwd_4_c;
	logic [15:0]       fwd_0_c;
	logic [15:0]       fwd_1_c;
	logic [2:0]        level_3_c;
	logic [2:0]        level_4_c;
	logic [2:0]        level_0_c;
	logic [2:0]        level_1_c;
	logic [15:0]       fwd_3_q;
	logic [15:0]       fwd_4_q;
	logic [15:0]       fwd_0_q;
	logic [15:0]       fwd_1_q;
	logic [2:0]        level_3_q;
	logic [2:0]        level_4_q;
	logic [2:0]        level_0_q;
	logic [2:0]        level_1_q;

	// zero-wait slave: every transfer completes in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY[0];
	assign hrdata    = hrdata_q;

	// a transfer is taken on nonseq or seq while the bus is ready
	assign addr_ok = hsel & hready & htrans[1];

	// address phase is held until the data phase carries hwdata
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else
		begin
			wr_pend_q <= addr_ok & hwrite;
			if (addr_ok)
			begin
				wr_addr_q <= haddr[ADDR_W-1:0];
			end
		end
	end

	// data-phase write strobes; unmapped words match none
	assign wr_0 = wr_pend_q & word_hit(wr_addr_q, OFS_ENABLES_0);
	assign wr_1 = wr_pend_q & word_hit(wr_addr_q, OFS_ENABLES_1);
	assign wr_3 = wr_pend_q & word_hit(wr_addr_q, OFS_FLAGS_3);
	assign wr_4 = wr_pend_q & word_hit(wr_addr_q, OFS_FLAGS_4);

	// source pulses placed at their flag positions
	always_comb
	begin
		set_3                    = '0;
		set_3[POS_DMA_CH5_DONE]  = dma_ch5_done_req;
		set_3[POS_CAN2_EVENT]    = can2_event_req;
		set_3[POS_CAN2_RX_READY] = can2_rx_ready_req;
		set_3[POS_EXT_IRQ4]      = ext_irq4_req;
		set_3[POS_EXT_IRQ3]      = ext_irq3_req;
		set_3[POS_TIMER9]        = timer9_req;
		set_3[POS_TIMER8]        = timer8_req;
		set_3[POS_I2C2_MASTER]   = i2c2_master_event_req;
		set_3[POS_I2C2_SLAVE]    = i2c2_slave_event_req;
		set_3[POS_TIMER7]        = timer7_req;
	end

	// fourth flag register has only six live bits
	always_comb
	begin
		set_4                      = '0;
		set_4[POS_CAN2_TX_REQUEST] = can2_tx_request_req;
		set_4[POS_CAN1_TX_REQUEST] = can1_tx_request_req;
		set_4[POS_DMA_CH7_DONE]    = dma_ch7_done_req;
		set_4[POS_DMA_CH6_DONE]    = dma_ch6_done_req;
		set_4[POS_UART2_ERROR]     = uart2_error_req;
		set_4[POS_UART1_ERROR]     = uart1_error_req;
	end

	// next bank values; masks keep unimplemented bits at zero
	assign irq_flags_3_d = next_flags(irq_flags_3_q, wr_3, hwdata[15:0],
		set_3, IMPL_FLAGS_3);
	assign irq_flags_4_d = next_flags(irq_flags_4_q, wr_4, hwdata[15:0],
		set_4, IMPL_FLAGS_4);
	assign irq_enables_0_d = next_enables(irq_enables_0_q, wr_0,
		hwdata[15:0], IMPL_ENABLES_0);
	assign irq_enables_1_d = next_enables(irq_enables_1_q, wr_1,
		hwdata[15:0], IMPL_ENABLES_1);

	// flags are sticky: only a software write of zero clears one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_flags_3_q <= RST_BANK;
			irq_flags_4_q <= RST_BANK;
		end
		else
		begin
			irq_flags_3_q <= irq_flags_3_d;
			irq_flags_4_q <= irq_flags_4_d;
		end
	end

	// enable banks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			irq_enables_0_q <= RST_BANK;
			irq_enables_1_q <= RST_BANK;
		end
		else
		begin
			irq_enables_0_q <= irq_enables_0_d;
			irq_enables_1_q <= irq_enables_1_d;
		end
	end

	// read data is taken from the next values, so a read right
	// behind a write or a hardware set already sees the new bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata_q <= RDATA_ZERO;
		end
		else if (addr_ok && !hwrite)
		begin
			if (word_hit(haddr[ADDR_W-1:0], OFS_FLAGS_3))
			begin
				hrdata_q <= {16'h0000, irq_flags_3_d};
			end
			else if (word_hit(haddr[ADDR_W-1:0], OFS_FLAGS_4))
			begin
				hrdata_q <= {16'h0000, irq_flags_4_d};
			end
			else if (word_hit(haddr[ADDR_W-1:0], OFS_ENABLES_0))
			begin
				hrdata_q <= {16'h0000, irq_enables_0_d};
			end
			else if (word_hit(haddr[ADDR_W-1:0], OFS_ENABLES_1))
			begin
				hrdata_q <= {16'h0000, irq_enables_1_d};
			end
			else
			begin
				hrdata_q <= RDATA_ZERO; // unmapped words read zero
			end
		end
	end

	// gating and level pick, one instance per bank
	ifeb_prio_gate #(.WIDTH(16)) u_gate_3 (
		.req_flags   (irq_flags_3_q),
		.req_enables (enables_3_in & IMPL_FLAGS_3),
		.prio_codes  (prio_3_in),
		.fwd         (fwd_3_c),
		.top_level   (level_3_c)
	);

	ifeb_prio_gate #(.WIDTH(16)) u_gate_4 (
		.req_flags   (irq_flags_4_q),
		.req_enables (enables_4_in & IMPL_FLAGS_4),
		.prio_codes  (prio_4_in),
		.fwd         (fwd_4_c),
		.top_level   (level_4_c)
	);

	ifeb_prio_gate #(.WIDTH(16)) u_gate_0 (
		.req_flags   (flags_0_in & IMPL_ENABLES_0),
		.req_enables (irq_enables_0_q),
		.prio_codes  (prio_0_in),
		.fwd         (fwd_0_c),
		.top_level   (level_0_c)
	);

	ifeb_prio_gate #(.WIDTH(16)) u_gate_1 (
		.req_flags   (flags_1_in & IMPL_ENABLES_1),
		.req_enables (irq_enables_1_q),
		.prio_codes  (prio_1_in),
		.fwd         (fwd_1_c),
		.top_level   (level_1_c)
	);

	// registered outputs to the prioritiser; costs one cycle of
	// latency but keeps the long gate tree off the next stage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fwd_3_q <= RST_BANK;
			fwd_4_q <= RST_BANK;
			fwd_0_q <= RST_BANK;
			fwd_1_q <= RST_BANK;
		end
		else
		begin
			fwd_3_q <= fwd_3_c;
			fwd_4_q <= fwd_4_c;
			fwd_0_q <= fwd_0_c;
			fwd_1_q <= fwd_1_c;
		end
	end

	// highest active level of each bank
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			level_3_q <= PRIO_OFF;
			level_4_q <= PRIO_OFF;
			level_0_q <= PRIO_OFF;
			level_1_q <= PRIO_OFF;
		end
		else
		begin
			level_3_q <= level_3_c;
			level_4_q <= level_4_c;
			level_0_q <= level_0_c;
			level_1_q <= level_1_c;
		end
	end

	// bank views for the rest of the controller
	assign irq_flags_3   = irq_flags_3_q;
	assign irq_flags_4   = irq_flags_4_q;
	assign irq_enables_0 = irq_enables_0_q;
	assign irq_enables_1 = irq_enables_1_q;

	// forwarded requests and levels
	assign fwd_3   = fwd_3_q;
	assign fwd_4   = fwd_4_q;
	assign fwd_0   = fwd_0_q;
	assign fwd_1   = fwd_1_q;
	assign level_3 = level_3_q;
	assign level_4 = level_4_q;
	assign level_0 = level_0_q;
	assign level_1 = level_1_q;

	// hsize is accepted as given; only whole-word use is supported
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:ADDR_W], hwdata[31:16], htrans[0]};

endmodule

// ==== rtl/ifeb_pkg.sv ====
package ifeb_pkg;

	// register window and word offsets
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFS_FLAGS_3     = 8'h00;
	localparam logic [7:0]  OFS_FLAGS_4     = 8'h04;
	localparam logic [7:0]  OFS_ENABLES_0   = 8'h08;
	localparam logic [7:0]  OFS_ENABLES_1   = 8'h0C;

	// implemented bits of each bank; the rest read zero
	localparam logic [15:0] IMPL_FLAGS_3    = 16'h21FF;
	localparam logic [15:0] IMPL_FLAGS_4    = 16'h00F6;
	localparam logic [15:0] IMPL_ENABLES_0  = 16'h7FFF;
	localparam logic [15:0] IMPL_ENABLES_1  = 16'hFFFB;

	// power-on value of every bank
	localparam logic [15:0] RST_BANK        = 16'h0000;

	// flag positions, third flag register
	localparam int POS_DMA_CH5_DONE         = 13;
	localparam int POS_CAN2_EVENT           = 8;
	localparam int POS_CAN2_RX_READY        = 7;
	localparam int POS_EXT_IRQ4             = 6;
	localparam int POS_EXT_IRQ3             = 5;
	localparam int POS_TIMER9               = 4;
	localparam int POS_TIMER8               = 3;
	localparam int POS_I2C2_MASTER          = 2;
	localparam int POS_I2C2_SLAVE           = 1;
	localparam int POS_TIMER7               = 0;

	// flag positions, fourth flag register
	localparam int POS_CAN2_TX_REQUEST      = 7;
	localparam int POS_CAN1_TX_REQUEST      = 6;
	localparam int POS_DMA_CH7_DONE         = 5;
	localparam int POS_DMA_CH6_DONE         = 4;
	localparam int POS_UART2_ERROR          = 2;
	localparam int POS_UART1_ERROR          = 1;

	// priority field
	localparam int          PRIO_W          = 3;
	localparam logic [2:0]  PRIO_OFF        = 3'h0;

	// ahb constants
	localparam logic [1:0]  HRESP_OKAY      = 2'h0;
	localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

endpackage

// ==== rtl/ifeb_prio_gate.sv ====
`timescale 1ns/1ps

module ifeb_prio_gate
	import ifeb_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic [WIDTH-1:0]        req_flags,   // pending flags
	input  wire logic [WIDTH-1:0]        req_enables, // per-source enables
	input  wire logic [WIDTH*PRIO_W-1:0] prio_codes,  // 3-bit code per source
	output logic      [WIDTH-1:0]        fwd,         // requests passed on
	output logic      [PRIO_W-1:0]       top_level    // highest level, 0 = none
);

	// flag and enable both high, and a nonzero priority code
	always_comb
	begin
		for (int i = 0; i < WIDTH; i++)
		begin
			fwd[i] = req_flags[i] & req_enables[i]
				& (prio_codes[i*PRIO_W +: PRIO_W] != PRIO_OFF);
		end
	end

	// 111 is level 7, the highest; 000 never wins
	always_comb
	begin
		top_level = PRIO_OFF;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (fwd[i] && prio_codes[i*PRIO_W +: PRIO_W] > top_level)
			begin
				top_level = prio_codes[i*PRIO_W +: PRIO_W];
			end
		end
	end

endmodule

// ==== testbench/ifeb_irq_flag_enable_bank_tb.sv ====
`timescale 1ns/1ps

module ifeb_irq_flag_enable_bank_tb;
	import ifeb_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] cmd = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_7978;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [15:0] req_3;
	logic [15:0] req_4;
	logic [15:0] ext[4] = '{default: 16'h0000};
	logic [47:0] prio[4] = '{default: 48'h0};
	logic [15:0] regv[4];
	logic [15:0] fwd[4];
	logic [2:0]  lvl[4];
	logic [15:0] m[4];
	logic [15:0] impl[4] = '{16'h21FF, 16'h00F6, 16'h7FFF, 16'hFFFB};
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	wire         hready = hreadyout;

	ifeb_irq_flag_enable_bank i_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hreadyout, .hresp, .hrdata,
		.dma_ch5_done_req(req_3[13]), .can2_event_req(req_3[8]), .can2_rx_ready_req(req_3[7]),
		.ext_irq4_req(req_3[6]), .ext_irq3_req(req_3[5]), .timer9_req(req_3[4]), .timer8_req(req_3[3]),
		.i2c2_master_event_req(req_3[2]), .i2c2_slave_event_req(req_3[1]), .timer7_req(req_3[0]),
		.can2_tx_request_req(req_4[7]), .can1_tx_request_req(req_4[6]), .dma_ch7_done_req(req_4[5]),
		.dma_ch6_done_req(req_4[4]), .uart2_error_req(req_4[2]), .uart1_error_req(req_4[1]),
		.enables_3_in(ext[0]), .enables_4_in(ext[1]), .flags_0_in(ext[2]), .flags_1_in(ext[3]),
		.prio_3_in(prio[0]), .prio_4_in(prio[1]), .prio_0_in(prio[2]), .prio_1_in(prio[3]),
		.irq_flags_3(regv[0]), .irq_flags_4(regv[1]), .irq_enables_0(regv[2]), .irq_enables_1(regv[3]),
		.fwd_3(fwd[0]), .fwd_4(fwd[1]), .fwd_0(fwd[2]), .fwd_1(fwd[3]),
		.level_3(lvl[0]), .level_4(lvl[1]), .level_0(lvl[2]), .level_1(lvl[3])
	);

	ifeb_src_model i_src (.hclk, .hresetn, .cmd, .req_3, .req_4);

	// 200 MHz clock
	always #2.5 hclk = ~hclk;

	// hang guard: far above the roughly 560 cycles the tests need
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	function logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// single word transfer; every wait is cut short only by the hang guard
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input int b, input logic [31:0] d);
		logic [31:0] rd;
		ahb(1'b1, 32'(4 * b), d, rd);
		m[b] = d[15:0] & impl[b];
	endtask

	task automatic rd_chk(input int b);
		logic [31:0] rd;
		ahb(1'b0, 32'(4 * b), 32'h0000_0000, rd);
		chk(rd, {16'h0000, m[b]});
		chk(regv[b], m[b]);
	endtask

	// forwarding needs flag, enable and a nonzero code; level is the top code
	task automatic fwd_chk(input int b);
		logic [15:0] f;
		logic [2:0]  l;
		f = 16'h0000;
		l = 3'h0;
		for (int i = 0; i < 16; i++)
			if (m[b][i] && ext[b][i] && impl[b][i] && prio[b][3*i +: 3] != 3'h0)
			begin
				f[i] = 1'b1;
				if (prio[b][3*i +: 3] > l)
					l = prio[b][3*i +: 3];
			end
		chk(fwd[b], f);
		chk(lvl[b], l);
	endtask

	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		m = '{default: 16'h0000};
		@(posedge hclk);
	endtask

	initial
	begin
		logic [31:0] rd;
		logic [63:0] r;
		do_reset();
		// reset values, write masks and clears of all banks
		for (int b = 0; b < 4; b++)
		begin
			rd_chk(b);
			wr(b, 32'hFFFF_FFFF);
			rd_chk(b);
			wr(b, 32'h0000_0000);
			rd_chk(b);
		end
		$display("test bank masks done");
		// unmapped word reads zero and a write there leaves the flags 3 bank unchanged
		wr(0, 32'h0000_2001);
		ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
		ahb(1'b0, 32'h0000_0010, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		rd_chk(0);
		// start the source sweep from an empty bank, so that every set is visible
		wr(0, 32'h0000_0000);
		rd_chk(0);
		$display("test unmapped done");
		// every source sets its own flag, which stays until written to zero
		for (int k = 0; k < 32; k++)
			if (impl[k / 16][k % 16])
			begin
				cmd <= 32'h0000_0001 << k;
				@(posedge hclk);
				cmd <= 32'h0000_0000;
				repeat (3) @(posedge hclk);
				m[k / 16][k % 16] = 1'b1;
				rd_chk(k / 16);
				repeat (5) @(posedge hclk);
				rd_chk(k / 16);
				wr(k / 16, 32'h0000_0000);
				rd_chk(k / 16);
			end
		$display("test sources done");
		// a one-cycle source pulse in the data phase of a clearing write wins
		fork
			wr(0, 32'h0000_0000);
			begin
				cmd <= 32'h0000_0001;
				@(posedge hclk);
				cmd <= 32'h0000_0000;
			end
		join
		m[0][0] = 1'b1;
		rd_chk(0);
		wr(0, 32'h0000_0000);
		rd_chk(0);
		$display("test set beats clear done");
		// random banks, gates and codes against the model
		for (int n = 0; n < 48; n++)
		begin
			r = {xorshift(), xorshift()};
			ext[n % 4] <= r[15:0];
			prio[n % 4] <= r[63:16];
			wr(n % 4, xorshift());
			repeat (2) @(posedge hclk);
			fwd_chk(n % 4);
		end
		$display("test forwarding done");
		// second reset in mid-run clears everything again
		do_reset();
		for (int b = 0; b < 4; b++)
		begin
			rd_chk(b);
			fwd_chk(b);
		end
		$display("test second reset done");
		give_verdict();
	end
endmodule

// ==== testbench/ifeb_monitor.sv ====
`timescale 1ns/1ps

module ifeb_monitor
	import ifeb_pkg::*;
(
	input wire logic        hclk,            // clock
	input wire logic        hresetn,         // reset, low
	input wire logic        hsel,            // select
	input wire logic [1:0]  htrans,          // type
	input wire logic        hwrite,          // write
	input wire logic        hready,          // ready in
	input wire logic        hreadyout,       // ready out
	input wire logic        hresp,           // response
	input wire logic [31:0] hrdata,          // read data
	input wire logic        timer7_req,      // source
	input wire logic        uart1_error_req, // source
	input wire logic [15:0] irq_flags_3,     // bank
	input wire logic [15:0] irq_flags_4,     // bank
	input wire logic [15:0] irq_enables_0,   // bank
	input wire logic [15:0] irq_enables_1,   // bank
	input wire logic [15:0] flags_0_in,      // ext flags
	input wire logic [15:0] fwd_0,           // forwarded
	input wire logic [2:0]  level_0          // top level
);
	logic wr_ph_q;

	// marks a write data phase; a flag may only drop right after one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_ph_q <= 1'b0;
		else
			wr_ph_q <= hsel & hready & htrans[1] & hwrite;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_zero_wait_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_upper_zero: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_flags3_unimpl: assert property ((irq_flags_3 & 16'hDE00) == 16'h0000)
		else $error("unimplemented flag bit set in bank 3");
	a_flags4_unimpl: assert property ((irq_flags_4 & 16'hFF09) == 16'h0000)
		else $error("unimplemented flag bit set in bank 4");
	a_en0_unimpl: assert property ((irq_enables_0 & 16'h8000) == 16'h0000)
		else $error("unimplemented enable bit set in bank 0");
	a_en1_unimpl: assert property ((irq_enables_1 & 16'h0004) == 16'h0000)
		else $error("unimplemented enable bit set in bank 1");
	a_timer7_sets: assert property (timer7_req |=> irq_flags_3[0])
		else $error("timer7 request did not set its flag");
	a_uart1_err_sets: assert property (uart1_error_req |=> irq_flags_4[1])
		else $error("uart1 error request did not set its flag");
	a_flag4_sticks: assert property (|($past(irq_flags_4) & ~irq_flags_4) |-> $past(wr_ph_q))
		else $error("bank 4 flag cleared without a write");
	a_flag3_sticks: assert property (|($past(irq_flags_3) & ~irq_flags_3) |-> $past(wr_ph_q))
		else $error("bank 3 flag cleared without a write");
	a_fwd_gated: assert property ((fwd_0 & ~$past(flags_0_in & irq_enables_0)) == 16'h0000)
		else $error("request forwarded without flag and enable");
	a_level_idle: assert property (fwd_0 == 16'h0000 |-> level_0 == 3'h0)
		else $error("level shown with nothing forwarded");

	// main scenarios reached
	c_source: cover property (timer7_req);
	c_write: cover property (wr_ph_q);
	c_forward: cover property (fwd_0 != 16'h0000);
	c_top_level: cover property (level_0 == 3'h7);
endmodule

bind ifeb_irq_flag_enable_bank ifeb_monitor i_mon (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
	.timer7_req, .uart1_error_req, .irq_flags_3, .irq_flags_4, .irq_enables_0,
	.irq_enables_1, .flags_0_in, .fwd_0, .level_0
);

// ==== testbench/ifeb_src_model.sv ====
`timescale 1ns/1ps

module ifeb_src_model
(
	input  wire logic        hclk,    // clock
	input  wire logic        hresetn, // reset, low
	input  wire logic [31:0] cmd,     // bank 4 high, bank 3 low
	output logic      [15:0] req_3,   // pulses, flags 3
	output logic      [15:0] req_4    // pulses, flags 4
);
	// each command bit becomes one request cycle; only wired sources ever pulse
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_3 <= 16'h0000;
			req_4 <= 16'h0000;
		end
		else
		begin
			req_3 <= cmd[15:0] & 16'h21FF;
			req_4 <= cmd[31:16] & 16'h00F6;
		end
	end
endmodule
